// ===== rtl/overload_pulse_timer.sv
`timescale 1ns/100ps
// Pulsed overload protection: long off period, short on period, repeat
module overload_pulse_timer #(
    parameter int unsigned OFF_CYCLES = satellite_supply_pkg::OFF_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Pulsed mode selected and output powered
    input wire logic enable,
    input wire logic overload,
    // Protection state
    output logic outputOff,
    output logic overloadFlag
);
    localparam logic [31:0] OFF_COUNT = 32'(OFF_CYCLES);
    localparam logic [31:0] ON_COUNT = 32'(OFF_CYCLES / satellite_supply_pkg::ON_DIVISOR);

    typedef enum logic [1:0] {P_NORMAL, P_OFF, P_ON} pulse_state_e;
    typedef struct packed {
        pulse_state_e state;
        logic [31:0] count; // Cycles left in the current period
        logic seen;         // Overload seen during the on period
        logic flag;
    } pulse_s;

    pulse_s p;
    pulse_s next_p;

    // Period sequencing
    always_comb
    begin
        next_p = p;
        if (!enable)
        begin
            next_p = '0;
        end
        else
        begin
            case (p.state)
                P_NORMAL:
                begin
                    if (overload)
                    begin
                        next_p.state = P_OFF;
                        next_p.count = OFF_COUNT;
                        next_p.flag = 1'b1;
                    end
                end
                P_OFF:
                begin
                    next_p.count = p.count - 32'h0000_0001;
                    if (p.count <= 32'h0000_0001)
                    begin
                        next_p.state = P_ON;
                        next_p.count = ON_COUNT;
                        next_p.seen = 1'b0;
                    end
                end
                P_ON:
                begin
                    next_p.count = p.count - 32'h0000_0001;
                    next_p.seen = p.seen | overload;
                    if (p.count <= 32'h0000_0001)
                    begin
                        // A clean full on period ends the cycling
                        if (p.seen | overload)
                        begin
                            next_p.state = P_OFF;
                            next_p.count = OFF_COUNT;
                        end
                        else
                        begin
                            next_p.state = P_NORMAL;
                            next_p.flag = 1'b0;
                        end
                    end
                end
                default:
                    next_p = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            p <= '0;
        else
            p <= next_p;
    end

    assign outputOff = (p.state == P_OFF);
    assign overloadFlag = p.flag;

    property p_off_to_on;
        @(posedge clock) disable iff (!arst_n)
        (enable && p.state == P_OFF && p.count == 32'h0000_0001) |=> (p.state == P_ON);
    endproperty
    a_off_to_on: assert property (p_off_to_on)
        else $error("off period did not hand over to on period");

    property p_trip_sets_flag;
        @(posedge clock) disable iff (!arst_n)
        (enable && p.state == P_NORMAL && overload) |=> (p.flag && p.state == P_OFF);
    endproperty
    a_trip_sets_flag: assert property (p_trip_sets_flag)
        else $error("overload did not start off period with flag");
endmodule // overload_pulse_timer

// ===== rtl/satellite_supply_i2c_control.sv
`timescale 1ns/100ps
module satellite_supply_i2c_control #(
    parameter int unsigned OFF_CYCLES = satellite_supply_pkg::OFF_CYCLES
) (
    // Core clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Link sampling clock
    input wire logic linkClock,
    // Serial bus pins, open drain data
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Board and analog status pins
    input wire logic [1:0] busIdSelect,
    input wire logic undervoltageLockout,
    input wire logic toneGateInput,
    input wire logic thermalShutdown,
    input wire logic overloadDetect,
    // Power stage controls
    output logic regulatorOn,
    output logic txPathOutput,
    output logic rxPathOutput,
    output logic toneOn,
    output logic [1:0] levelCode,
    output logic staticClamp,
    // Diagnostic flags
    output logic thermalFlag,
    output logic overloadFlag
);
    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_WDATA, L_WDATA_ACK, L_RDATA, L_RACK, L_IGNORE
    } link_state_e;

    // Link side state, all on linkClock
    typedef struct packed {
        link_state_e state;
        logic prevScl;     // Bus levels one sample back
        logic prevSda;
        logic [2:0] count; // Bits clocked in the current byte
        logic byteDone;    // Eighth bit has been clocked
        logic [7:0] shift;
        logic readMode;
        logic masterAck;
        logic drive;       // Pulling the data line low
        logic [7:0] wrData; // Held stable until the next byte completes
        logic wrToggle;
        logic [7:0] readByte;
        logic rdSeen;      // Echo of the core snapshot toggle
    } link_s;

    // Core side state, all on clock
    typedef struct packed {
        logic [5:0] ctrl;
        logic thermal;
        logic overload;
        logic [7:0] snap;  // Held stable while the link copies it
        logic rdToggle;
        logic wrSeen;
        logic regulator;
        logic tx;
        logic rx;
        logic tone;
        logic [1:0] level;
        logic clamp;
    } core_s;

    link_s l;
    link_s next_l;
    core_s c;
    core_s next_c;

    // Synchronised inputs of both domains
    logic uvloL, sclS, sdaS, rdTogL;
    logic [1:0] idSel;
    logic uvloC, gateC, thermC, overC, wrTogC, rdSeenC;
    logic offPeriod, pulsedFlag;
    logic start, stop, sclRise, sclFall, match, quiet;
    logic wrEvent;
    logic [7:0] sysReg;

    // Seven-bit address from the identity select
    function automatic logic [6:0] own_address(input logic [1:0] sel);
        own_address = satellite_supply_pkg::ADDRESS_BASE + {5'h00, sel};
    endfunction

    sync_bits #(.WIDTH(6)) u_link_sync (
        .clock(linkClock),
        .arst_n(arst_n),
        .async({undervoltageLockout, sclIn, sdaIn, c.rdToggle, busIdSelect}),
        .synced({uvloL, sclS, sdaS, rdTogL, idSel})
    );

    sync_bits #(.WIDTH(6)) u_core_sync (
        .clock(clock),
        .arst_n(arst_n),
        .async({undervoltageLockout, toneGateInput, thermalShutdown, overloadDetect,
                l.wrToggle, l.rdSeen}),
        .synced({uvloC, gateC, thermC, overC, wrTogC, rdSeenC})
    );

    overload_pulse_timer #(.OFF_CYCLES(OFF_CYCLES)) u_pulse (
        .clock(clock),
        .arst_n(arst_n),
        .enable(!c.ctrl[satellite_supply_pkg::BIT_STATIC_LIMIT - 2] &&
                c.ctrl[satellite_supply_pkg::BIT_POWER - 2]),
        .overload(overC),
        .outputOff(offPeriod),
        .overloadFlag(pulsedFlag)
    );

    // Bus condition decode on synchronised samples
    always_comb
    begin
        start = l.prevScl & sclS & l.prevSda & ~sdaS;
        stop = l.prevScl & sclS & ~l.prevSda & sdaS;
        sclRise = ~l.prevScl & sclS;
        sclFall = l.prevScl & ~sclS;
        match = (l.shift[7:1] == own_address(idSel));
        quiet = l.prevScl & sclS & ~start & ~stop & ~uvloL;
    end

    // Link protocol engine; outside lockout, data line moves only after a clock fall, a start or a stop
    always_comb
    begin
        next_l = l;
        next_l.prevScl = sclS;
        next_l.prevSda = sdaS;
        // Copy a fresh register snapshot when the core offers one
        if (rdTogL != l.rdSeen)
        begin
            next_l.readByte = c.snap;
            next_l.rdSeen = rdTogL;
        end
        if (uvloL)
        begin
            next_l.state = L_IDLE;
            next_l.drive = 1'b0;
        end
        else if (start)
        begin
            // Repeated start is not expected, but is taken as a fresh one
            next_l.state = L_ADDR;
            next_l.count = 3'h0;
            next_l.byteDone = 1'b0;
            next_l.drive = 1'b0;
        end
        else if (stop)
        begin
            next_l.state = L_IDLE;
            next_l.drive = 1'b0;
        end
        else
        begin
            case (l.state)
                L_ADDR, L_WDATA:
                begin
                    if (sclRise)
                    begin
                        next_l.shift = {l.shift[6:0], sdaS};
                        next_l.count = l.count + 3'h1;
                        next_l.byteDone = (l.count == 3'h7);
                    end
                    else if (sclFall && l.byteDone)
                    begin
                        next_l.byteDone = 1'b0;
                        if (l.state == L_WDATA)
                        begin
                            next_l.state = L_WDATA_ACK;
                            next_l.drive = 1'b1;
                            next_l.wrData = l.shift;
                            next_l.wrToggle = ~l.wrToggle;
                        end
                        else if (match)
                        begin
                            next_l.state = L_ADDR_ACK;
                            next_l.drive = 1'b1;
                            next_l.readMode = l.shift[0];
                        end
                        else
                        begin
                            next_l.state = L_IGNORE;
                        end
                    end
                end
                L_ADDR_ACK, L_WDATA_ACK:
                begin
                    if (sclFall)
                    begin
                        next_l.count = 3'h0;
                        if (l.state == L_ADDR_ACK && l.readMode)
                        begin
                            next_l.state = L_RDATA;
                            next_l.shift = l.readByte;
                            next_l.drive = ~l.readByte[7];
                        end
                        else
                        begin
                            next_l.state = L_WDATA;
                            next_l.drive = 1'b0;
                        end
                    end
                end
                L_RDATA:
                begin
                    if (sclRise)
                    begin
                        next_l.count = l.count + 3'h1;
                        next_l.byteDone = (l.count == 3'h7);
                    end
                    else if (sclFall)
                    begin
                        if (l.byteDone)
                        begin
                            next_l.state = L_RACK;
                            next_l.byteDone = 1'b0;
                            next_l.drive = 1'b0;
                        end
                        else
                        begin
                            next_l.shift = {l.shift[6:0], 1'b0};
                            next_l.drive = ~l.shift[6];
                        end
                    end
                end
                L_RACK:
                begin
                    if (sclRise)
                    begin
                        next_l.masterAck = ~sdaS;
                    end
                    else if (sclFall)
                    begin
                        next_l.count = 3'h0;
                        if (l.masterAck)
                        begin
                            next_l.state = L_RDATA;
                            next_l.shift = l.readByte;
                            next_l.drive = ~l.readByte[7];
                        end
                        else
                        begin
                            next_l.state = L_IGNORE;
                        end
                    end
                end
                L_IDLE, L_IGNORE:
                    next_l.drive = 1'b0;
                default:
                begin
                    next_l.state = L_IDLE;
                    next_l.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge linkClock or negedge arst_n)
    begin
        if (!arst_n)
            l <= '0;
        else
            l <= next_l;
    end

    // Core register, diagnostics and power stage decode
    always_comb
    begin
        next_c = c;
        wrEvent = (wrTogC != c.wrSeen);
        next_c.wrSeen = wrTogC;
        if (uvloC)
            next_c.ctrl = satellite_supply_pkg::REG_RESET[7:2];
        else if (wrEvent)
            next_c.ctrl = l.wrData[7:satellite_supply_pkg::CTRL_LSB];
        next_c.thermal = thermC;
        // Static mode flag tracks the overload detector directly
        if (c.ctrl[satellite_supply_pkg::BIT_STATIC_LIMIT - 2])
            next_c.overload = overC;
        else
            next_c.overload = pulsedFlag;
        sysReg = {c.ctrl, c.thermal, c.overload};
        // Offer a new snapshot only once the link has taken the last one
        if (rdSeenC == c.rdToggle)
        begin
            next_c.snap = sysReg;
            next_c.rdToggle = ~c.rdToggle;
        end
        next_c.regulator = c.ctrl[satellite_supply_pkg::BIT_POWER - 2] && !c.thermal &&
                           !uvloC && !offPeriod;
        next_c.tx = next_c.regulator && c.ctrl[satellite_supply_pkg::BIT_TX_SELECT - 2];
        next_c.rx = next_c.regulator && !c.ctrl[satellite_supply_pkg::BIT_TX_SELECT - 2];
        next_c.tone = next_c.regulator &&
                      (c.ctrl[satellite_supply_pkg::BIT_TONE_FORCE - 2] || gateC);
        next_c.level = {c.ctrl[satellite_supply_pkg::BIT_BOOST - 2],
                        c.ctrl[satellite_supply_pkg::BIT_HIGH_VOLTAGE - 2]};
        next_c.clamp = c.ctrl[satellite_supply_pkg::BIT_STATIC_LIMIT - 2];
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            c <= '0;
        else
            c <= next_c;
    end

    // Outputs straight from flops, except sdaOut which is tied low
    assign sdaOut = 1'b0;
    assign sdaOe = l.drive;
    assign regulatorOn = c.regulator;
    assign txPathOutput = c.tx;
    assign rxPathOutput = c.rx;
    assign toneOn = c.tone;
    assign levelCode = c.level;
    assign staticClamp = c.clamp;
    assign thermalFlag = c.thermal;
    assign overloadFlag = c.overload;

    property p_start_to_addr;
        @(posedge linkClock) disable iff (!arst_n)
        (start && !uvloL) |=> (l.state == L_ADDR && l.count == 3'h0 && !l.drive);
    endproperty
    a_start_to_addr: assert property (p_start_to_addr)
        else $error("start condition not taken");

    property p_stop_release;
        @(posedge linkClock) disable iff (!arst_n)
        (stop && !start) |=> (l.state == L_IDLE && !l.drive);
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("stop condition did not release the bus");

    property p_hold_while_high;
        @(posedge linkClock) disable iff (!arst_n)
        quiet |=> $stable(l.drive);
    endproperty
    a_hold_while_high: assert property (p_hold_while_high)
        else $error("data line changed while clock high");

    property p_lockout_silent;
        @(posedge linkClock) disable iff (!arst_n)
        uvloL |=> (!l.drive && l.state == L_IDLE);
    endproperty
    a_lockout_silent: assert property (p_lockout_silent)
        else $error("device responded during lockout");

    property p_mismatch_ignored;
        @(posedge linkClock) disable iff (!arst_n)
        (l.state == L_ADDR && l.byteDone && sclFall && !match && !uvloL && !start && !stop)
            |=> (l.state == L_IGNORE && !l.drive);
    endproperty
    a_mismatch_ignored: assert property (p_mismatch_ignored)
        else $error("foreign address was not ignored");

    property p_data_acked;
        @(posedge linkClock) disable iff (!arst_n)
        (l.state == L_WDATA && l.byteDone && sclFall && !uvloL && !start && !stop)
            |=> (l.drive && l.wrToggle != $past(l.wrToggle));
    endproperty
    a_data_acked: assert property (p_data_acked)
        else $error("written byte not acknowledged or not passed on");

    property p_write_control_only;
        @(posedge clock) disable iff (!arst_n)
        (wrEvent && !uvloC) |=> (c.ctrl == $past(l.wrData[7:2]));
    endproperty
    a_write_control_only: assert property (p_write_control_only)
        else $error("write did not land in control bits");

    property p_lockout_clears;
        @(posedge clock) disable iff (!arst_n)
        uvloC |=> (c.ctrl == 6'h00) ##1 (!c.regulator && !c.tx && !c.rx);
    endproperty
    a_lockout_clears: assert property (p_lockout_clears)
        else $error("lockout did not clear the register");

    property p_standby;
        @(posedge clock) disable iff (!arst_n)
        !c.ctrl[0] |=> (!c.regulator && !c.tx && !c.rx && !c.tone);
    endproperty
    a_standby: assert property (p_standby)
        else $error("power stage active in standby");
endmodule // satellite_supply_i2c_control

// ===== rtl/satellite_supply_pkg.sv
package satellite_supply_pkg;
    // Seven-bit target address when the identity select reads zero
    localparam logic [6:0] ADDRESS_BASE = 7'h08;
    // System register value after power-on or lockout
    localparam logic [7:0] REG_RESET = 8'h00;
    // System register bit positions, most significant first
    localparam int BIT_STATIC_LIMIT = 7;
    localparam int BIT_TX_SELECT = 6;
    localparam int BIT_TONE_FORCE = 5;
    localparam int BIT_BOOST = 4;
    localparam int BIT_HIGH_VOLTAGE = 3;
    localparam int BIT_POWER = 2;
    localparam int BIT_THERMAL = 1;
    localparam int BIT_OVERLOAD = 0;
    // Lowest bit of the six writable control bits
    localparam int CTRL_LSB = 2;
    // Core clock rate
    localparam int CLOCK_HZ = 125_000_000;
    // Pulsed protection off time, in milliseconds
    localparam int OFF_TIME_MS = 900;
    // Off time in core cycles
    localparam int OFF_CYCLES = OFF_TIME_MS * (CLOCK_HZ / 1000);
    // On time is the off time divided by this
    localparam int ON_DIVISOR = 10;
endpackage

// ===== rtl/sync_bits.sv
`timescale 1ns/100ps
// Two-flop synchroniser for independent levels
module sync_bits #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Levels from another domain
    input wire logic [WIDTH-1:0] async,
    // Levels safe to use in this domain
    output logic [WIDTH-1:0] synced
);
    typedef struct packed {
        logic [WIDTH-1:0] first; // Only the second stage reads this
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s s;
    sync_s next_s;

    // Shift one stage per edge
    always_comb
    begin
        next_s.first = async;
        next_s.second = s.first;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign synced = s.second;
endmodule // sync_bits

// ===== tb/i2c_host_model.sv
`timescale 1ns/100ps
// Serial bus master; every change lands on a core clock edge
module i2c_host_model (
    // Clock and resolved data wire
    input wire logic clock,
    input wire logic sdaWire,
    // Master side of the bus
    output logic scl,
    output logic sdaDrive
);
    // Bus idles released, both lines high
    initial
    begin
        scl = 1'b1;
        sdaDrive = 1'b1;
    end
    // Half bit period, well over four link clocks
    task automatic half();
        repeat (10) @(posedge clock);
    endtask
    // Data falls while clock high
    task automatic start();
        sdaDrive <= 1'b0;
        half();
        scl <= 1'b0;
        half();
    endtask
    // Data rises while clock high; always sent before the next start
    task automatic stop();
        sdaDrive <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sdaDrive <= 1'b1;
        half();
    endtask
    // Data set while clock low, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        sdaDrive <= b;
        half();
        scl <= 1'b1;
        half();
        r = sdaWire;
        scl <= 1'b0;
        half();
    endtask
    // Eight bits then the ninth clock; ackIn high releases the line
    task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ackIn, ack);
    endtask
endmodule // i2c_host_model

// ===== tb/satellite_supply_i2c_control_test.sv
`timescale 1ns/100ps
module satellite_supply_i2c_control_test;
    // Stimulus, initial values given at time zero
    logic clock = 1'b0;
    logic linkClock = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] busIdSelect = 2'h0;
    logic undervoltageLockout = 1'b0;
    logic toneGateInput = 1'b0;
    logic thermalShutdown = 1'b0;
    logic overloadDetect = 1'b0;
    // Bus wires
    logic scl, sdaDrive, sdaOut, sdaOe, sdaWire;
    // Observed outputs
    logic regulatorOn, txPathOutput, rxPathOutput, toneOn, staticClamp, thermalFlag, overloadFlag;
    logic [1:0] levelCode;
    int bad_count = 0;
    int checks_done = 0;
    // Reference copy of the system register
    int modelReg = 0;
    logic [31:0] seed = 32'h00007567;
    // Pull-up wire: low while either side pulls
    assign sdaWire = sdaDrive & ~(sdaOe & ~sdaOut);
    initial forever #4 clock = ~clock;
    // Link clock phase unrelated to the core clock
    initial
    begin
        #3.1;
        forever #6 linkClock = ~linkClock;
    end
    // Short off period keeps the pulsed timer cheap
    satellite_supply_i2c_control #(.OFF_CYCLES(100)) dut (.clock, .arst_n, .linkClock,
        .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOe, .busIdSelect, .undervoltageLockout,
        .toneGateInput, .thermalShutdown, .overloadDetect, .regulatorOn, .txPathOutput,
        .rxPathOutput, .toneOn, .levelCode, .staticClamp, .thermalFlag, .overloadFlag);
    i2c_host_model host (.clock, .sdaWire, .scl, .sdaDrive);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Start, address, one byte, stop; the master never stops on a missing ack
    task automatic transact(input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] q,
        output logic a0, output logic a1);
        host.start();
        host.xfer(adr, 1'b1, q, a0);
        host.xfer(adr[0] ? 8'hFF : dat, 1'b1, q, a1);
        host.stop();
    endtask
    task automatic wr(input logic [6:0] adr, input logic [7:0] d, input logic acked);
        logic [7:0] q;
        logic a0, a1;
        transact({adr, 1'b0}, d, q, a0, a1);
        chk({6'h00, a0, a1}, acked ? 8'h00 : 8'h03);
        if (acked)
            modelReg = (modelReg & 3) | (d & 8'hFC);
    endtask
    // Output pins then a read back, both against the reference
    task automatic verify(input logic [6:0] adr);
        logic [7:0] q, e;
        logic a0, a1, on;
        repeat (30) @(posedge clock);
        on = modelReg[2] & ~thermalShutdown;
        e = {modelReg[7], on & modelReg[6], on & ~modelReg[6], 5'h00};
        e[4] = on & (modelReg[5] | toneGateInput);
        e[3:1] = {modelReg[4:3], on};
        chk({staticClamp, txPathOutput, rxPathOutput, toneOn, levelCode, regulatorOn, 1'b0},
            e);
        chk({6'h00, thermalFlag, overloadFlag}, {6'h00, thermalShutdown, overloadDetect});
        transact({adr, 1'b1}, 8'h00, q, a0, a1);
        chk({7'h00, a0}, 8'h00);
        chk(q, {modelReg[7:2], thermalShutdown, overloadDetect});
    endtask
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clock);
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (5) @(posedge clock);
        verify(7'h08);
        $display("test reset done");
        // Every level code, random other bits and tone gate
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            toneGateInput <= seed[8];
            wr(7'h08, {seed[7:5], i[1:0], seed[2:0]}, 1'b1);
            verify(7'h08);
        end
        $display("test write read done");
        wr(7'h0A, 8'hFF, 1'b0);
        busIdSelect <= 2'h2;
        wr(7'h0A, 8'hE4, 1'b1);
        verify(7'h0A);
        busIdSelect <= 2'h0;
        $display("test address done");
        // Static clamp with both faults present
        thermalShutdown <= 1'b1;
        overloadDetect <= 1'b1;
        wr(7'h08, 8'h84, 1'b1);
        verify(7'h08);
        thermalShutdown <= 1'b0;
        overloadDetect <= 1'b0;
        $display("test flags done");
        // Pulsed limiting: overload trips the off period, a clean on period clears it
        wr(7'h08, 8'h04, 1'b1);
        overloadDetect <= 1'b1;
        repeat (20) @(posedge clock);
        chk({6'h00, overloadFlag, regulatorOn}, 8'h02);
        overloadDetect <= 1'b0;
        repeat (200) @(posedge clock);
        chk({6'h00, overloadFlag, regulatorOn}, 8'h01);
        // Master ack asks for a second copy of the register, nack ends it
        begin : read_twice
            logic [7:0] q;
            logic a;
            host.start();
            host.xfer({7'h08, 1'b1}, 1'b1, q, a);
            chk({7'h00, a}, 8'h00);
            host.xfer(8'hFF, 1'b0, q, a);
            chk(q, modelReg[7:0]);
            host.xfer(8'hFF, 1'b1, q, a);
            chk(q, modelReg[7:0]);
            host.stop();
        end
        verify(7'h08);
        $display("test pulsed done");
        undervoltageLockout <= 1'b1;
        wr(7'h08, 8'h7C, 1'b0);
        modelReg = 0;
        undervoltageLockout <= 1'b0;
        verify(7'h08);
        $display("test lockout done");
        print_verdict();
    end
endmodule // satellite_supply_i2c_control_test
